/* definite_time_undervoltage_trip.sv */
// Three-phase definite-time undervoltage start and trip logic.
// Assumes magnitudes and block input come from logic on clk.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Phase starts when magnitude is below start level and above block level.
// - Phase start held low while magnitude is at or below block level.
// - General start is high while any phase is started.
// - Trip only after delay expiry and when start-only is clear.
// - Operation select off, one, two or all; off disables all starts and trips.
// - Start-only flag, default zero, suppresses trips but keeps starts.
// - Operate delay in milliseconds, 50 to 60000, default 100.
// - Delay counts only while magnitude stays under the start level.
// - Per-phase trips kept inside; only per-phase starts are published.
// - Pair mode relabels channels as L12, L23 and L31.
// - Phase-to-phase magnitudes are used by default.
// - External block input clears all starts and trips.
module definite_time_undervoltage_trip
	import uv_trip_pkg::*;
#(
	parameter int CYCLES_PER_MS = uv_trip_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// APB slave
	input  wire logic [7:0]                   paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output var  logic [31:0]                  prdata,
	output var  logic                         pready,
	output var  logic                         pslverr,
	// Magnitudes from the upstream chain
	input  wire logic [uv_trip_pkg::MAG_W-1:0] phaseAMagnitude,
	input  wire logic [uv_trip_pkg::MAG_W-1:0] phaseBMagnitude,
	input  wire logic [uv_trip_pkg::MAG_W-1:0] phaseCMagnitude,
	input  wire logic [uv_trip_pkg::MAG_W-1:0] pairAbMagnitude,
	input  wire logic [uv_trip_pkg::MAG_W-1:0] pairBcMagnitude,
	input  wire logic [uv_trip_pkg::MAG_W-1:0] pairCaMagnitude,
	input  wire logic                         externalBlockInput,
	// Protection outputs
	output var  logic                         phaseAStart,
	output var  logic                         phaseBStart,
	output var  logic                         phaseCStart,
	output var  logic                         generalStartOut,
	output var  logic                         generalTripOut,
	output var  logic                         pairLabels,
	output var  logic                         irq
);

	// Settings and interrupt state
	oper_t              operationSelect;
	logic               startOnlyFlag;
	logic               pairMode;
	logic [15:0]        startLevelSetting;
	logic [15:0]        blockingLevelSetting;
	logic [15:0]        dropoffRatioSetting;
	logic [15:0]        operateDelaySetting;
	logic [IRQ_W-1:0]   irqStatus;
	logic [IRQ_W-1:0]   irqMask;

	// Protection state
	logic [2:0]         phaseStart;
	logic [2:0]         phaseTrip;
	logic [15:0]        phaseTimer [3];
	logic [15:0]        msCount;
	logic               msTick;
	logic [MAG_W-1:0]   mag [3];
	logic [MAG_W-1:0]   pickLevel;
	logic [MAG_W-1:0]   dropLevel;
	logic [MAG_W-1:0]   blockLevel;
	logic               enabled;
	logic               next_generalStart;
	logic               next_generalTrip;
	logic [IRQ_W-1:0]   events;

	// Bus handshake terms
	logic               accessTaken;
	logic               writeTaken;
	logic [IRQ_W-1:0]   irqClear;
	logic [31:0]        next_prdata;
	logic               next_pslverr;

	// Keeps a written setting inside its legal range
	function automatic logic [15:0] clampSetting(
		input logic [31:0] value,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		if (value < {16'h0000, lo}) begin
			return lo;
		end else if (value > {16'h0000, hi}) begin
			return hi;
		end
		return value[15:0];
	endfunction : clampSetting

	// Number of set bits among three
	function automatic logic [1:0] countOnes(input logic [2:0] bits);
		return 2'(bits[0]) + 2'(bits[1]) + 2'(bits[2]);
	endfunction : countOnes

	// Tripped phases needed for a general trip under each selection
	function automatic logic [1:0] phasesNeeded(input oper_t sel);
		case (sel)
			OPER_ONE: return 2'h1;
			OPER_TWO: return 2'h2;
			OPER_ALL: return 2'h3;
			default:  return 2'h3;
		endcase
	endfunction : phasesNeeded

	// Percent setting times a factor, in magnitude units
	function automatic logic [MAG_W-1:0] scaled(
		input logic [15:0] pct,
		input logic [15:0] factor
	);
		logic [31:0] prod;
		prod = 32'(pct) * 32'(factor);
		return prod[MAG_W-1:0];
	endfunction : scaled

	// Channel source; upstream does all magnitude math
	always_comb begin
		if (pairMode) begin
			mag[0] = pairAbMagnitude;
			mag[1] = pairBcMagnitude;
			mag[2] = pairCaMagnitude;
		end else begin
			mag[0] = phaseAMagnitude;
			mag[1] = phaseBMagnitude;
			mag[2] = phaseCMagnitude;
		end
	end

	// Thresholds; max product 130 * 110 fits the width
	always_comb begin
		pickLevel  = scaled(startLevelSetting, 16'(PCT_SCALE));
		dropLevel  = scaled(startLevelSetting,
			16'(PCT_SCALE) + dropoffRatioSetting);
		blockLevel = scaled(blockingLevelSetting, 16'(PCT_SCALE));
	end

	// Off selection or external block stops the function
	assign enabled = (operationSelect != OPER_OFF)
		&& !externalBlockInput;

	// Per-phase start with hysteresis
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phaseStart <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!enabled) begin
					phaseStart[i] <= 1'b0;
				end else if (mag[i] <= blockLevel) begin
					phaseStart[i] <= 1'b0;
				end else if (mag[i] < pickLevel) begin
					phaseStart[i] <= 1'b1;
				end else if (mag[i] > dropLevel) begin
					phaseStart[i] <= 1'b0;
				end
			end
		end
	end

	// Millisecond prescaler, restarted while nothing is started
	// so the first tick lands a full millisecond after pickup
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			msCount <= 16'h0000;
			msTick  <= 1'b0;
		end else if (phaseStart == 3'h0) begin
			msCount <= 16'h0000;
			msTick  <= 1'b0;
		end else if (msCount == 16'(CYCLES_PER_MS - 1)) begin
			msCount <= 16'h0000;
			msTick  <= 1'b1;
		end else begin
			msCount <= msCount + 16'h0001;
			msTick  <= 1'b0;
		end
	end

	// Per-phase delay timers, in milliseconds, saturating
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 3; i++) begin
				phaseTimer[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!phaseStart[i] || !enabled) begin
					phaseTimer[i] <= 16'h0000;
				end else if (msTick && mag[i] < pickLevel
					&& phaseTimer[i] < operateDelaySetting) begin
					// Holds inside the hysteresis band
					phaseTimer[i] <= phaseTimer[i] + 16'h0001;
				end
			end
		end
	end

	// Internal per-phase trips, never driven to a pin
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			phaseTrip[i] = phaseStart[i]
				&& (phaseTimer[i] >= operateDelaySetting);
		end
	end

	// General start and trip decisions
	always_comb begin
		next_generalStart = enabled && (|phaseStart);
		next_generalTrip  = enabled && !startOnlyFlag
			&& (countOnes(phaseTrip)
			>= phasesNeeded(operationSelect));
		events = {next_generalTrip & ~generalTripOut,
			next_generalStart & ~generalStartOut};
	end

	// Registered protection outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			generalStartOut <= 1'b0;
			generalTripOut  <= 1'b0;
			pairLabels      <= PAIRS_DEF;
		end else begin
			generalStartOut <= next_generalStart;
			generalTripOut  <= next_generalTrip;
			pairLabels      <= pairMode;
		end
	end

	// Per-phase starts are the published flags
	assign phaseAStart = phaseStart[0];
	assign phaseBStart = phaseStart[1];
	assign phaseCStart = phaseStart[2];

	// APB: one wait state, write and read land when pready is high
	assign accessTaken = psel && penable && !pready;
	assign writeTaken  = psel && penable && pready && pwrite;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
		end else begin
			pready <= accessTaken;
		end
	end

	// Read mux and unmapped-address error
	always_comb begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		case (paddr)
			CTRL_ADDR: begin
				next_prdata[CTRL_OPER_MSB:CTRL_OPER_LSB] = operationSelect;
				next_prdata[CTRL_STONLY] = startOnlyFlag;
				next_prdata[CTRL_PAIRS]  = pairMode;
			end
			START_ADDR:  next_prdata[15:0] = startLevelSetting;
			BLOCK_ADDR:  next_prdata[15:0] = blockingLevelSetting;
			RATIO_ADDR:  next_prdata[15:0] = dropoffRatioSetting;
			DELAY_ADDR:  next_prdata[15:0] = operateDelaySetting;
			STATUS_ADDR: begin
				// Trip is general only; phase trips stay hidden
				next_prdata[5:0] = {pairMode, generalTripOut,
					generalStartOut, phaseStart};
			end
			IRQST_ADDR:  next_prdata[IRQ_W-1:0] = irqStatus;
			IRQMSK_ADDR: next_prdata[IRQ_W-1:0] = irqMask;
			default:     next_pslverr = 1'b1;
		endcase
	end

	// Read data and error captured for the ready cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (accessTaken) begin
			prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_pslverr;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Setting registers; out-of-range writes are clamped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			operationSelect      <= OPER_OFF;
			startOnlyFlag        <= 1'b0;
			pairMode             <= PAIRS_DEF;
			startLevelSetting    <= START_DEF;
			blockingLevelSetting <= BLOCK_DEF;
			dropoffRatioSetting  <= RATIO_DEF;
			operateDelaySetting  <= DELAY_DEF;
			irqMask              <= {IRQ_W{1'b0}};
		end else if (writeTaken) begin
			case (paddr)
				CTRL_ADDR: begin
					operationSelect <=
						oper_t'(pwdata[CTRL_OPER_MSB:CTRL_OPER_LSB]);
					startOnlyFlag   <= pwdata[CTRL_STONLY];
					pairMode        <= pwdata[CTRL_PAIRS];
				end
				START_ADDR: startLevelSetting <=
					clampSetting(pwdata, START_MIN, START_MAX);
				BLOCK_ADDR: blockingLevelSetting <=
					clampSetting(pwdata, BLOCK_MIN, BLOCK_MAX);
				RATIO_ADDR: dropoffRatioSetting <=
					clampSetting(pwdata, RATIO_MIN, RATIO_MAX);
				DELAY_ADDR: operateDelaySetting <=
					clampSetting(pwdata, DELAY_MIN, DELAY_MAX);
				IRQMSK_ADDR: irqMask <= pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Write-one-to-clear mask for the sticky status
	assign irqClear = (writeTaken && paddr == IRQST_ADDR)
		? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

	// Sticky events; a new event beats a same-cycle clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irqStatus <= {IRQ_W{1'b0}};
		end else begin
			irqStatus <= (irqStatus & ~irqClear) | events;
		end
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
		end
	end

endmodule : definite_time_undervoltage_trip
`default_nettype wire

/* uv_trip_pkg.sv */
// Constants shared by the undervoltage trip block.
// Assumes a 25 MHz clock and magnitudes in 0.01 % steps.
`default_nettype none
package uv_trip_pkg;

	// Clock and timing
	localparam int CLK_HZ       = 25_000_000;
	localparam int MS_PER_S     = 1000;
	localparam int MS_CYCLES    = CLK_HZ / MS_PER_S;

	// Magnitude width and units per percent
	localparam int MAG_W        = 16;
	localparam int PCT_SCALE    = 100;

	// APB register byte offsets
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] START_ADDR  = 8'h04;
	localparam logic [7:0] BLOCK_ADDR  = 8'h08;
	localparam logic [7:0] RATIO_ADDR  = 8'h0C;
	localparam logic [7:0] DELAY_ADDR  = 8'h10;
	localparam logic [7:0] STATUS_ADDR = 8'h14;
	localparam logic [7:0] IRQST_ADDR  = 8'h18;
	localparam logic [7:0] IRQMSK_ADDR = 8'h1C;

	// Control register fields
	localparam int CTRL_OPER_LSB = 0;
	localparam int CTRL_OPER_MSB = 1;
	localparam int CTRL_STONLY   = 2;
	localparam int CTRL_PAIRS    = 3;

	// Interrupt bits
	localparam int IRQ_W         = 2;
	localparam int IRQ_START     = 0;
	localparam int IRQ_TRIP      = 1;

	// Setting ranges and defaults
	localparam logic [15:0] START_MIN   = 16'h001E;
	localparam logic [15:0] START_MAX   = 16'h0082;
	localparam logic [15:0] START_DEF   = 16'h005A;
	localparam logic [15:0] BLOCK_MIN   = 16'h0000;
	localparam logic [15:0] BLOCK_MAX   = 16'h0014;
	localparam logic [15:0] BLOCK_DEF   = 16'h000A;
	localparam logic [15:0] RATIO_MIN   = 16'h0001;
	localparam logic [15:0] RATIO_MAX   = 16'h000A;
	localparam logic [15:0] RATIO_DEF   = 16'h0005;
	localparam logic [15:0] DELAY_MIN   = 16'h0032;
	localparam logic [15:0] DELAY_MAX   = 16'hEA60;
	localparam logic [15:0] DELAY_DEF   = 16'h0064;
	localparam logic        PAIRS_DEF   = 1'b1;

	// Operation selection
	typedef enum logic [1:0] {
		OPER_OFF = 2'h0,
		OPER_ONE = 2'h1,
		OPER_TWO = 2'h2,
		OPER_ALL = 2'h3
	} oper_t;

endpackage : uv_trip_pkg
`default_nettype wire

/* uv_trip_asserts.sv */
// Port checker for the undervoltage trip block.
// Assumes one clock domain; bound into the top module below.
`timescale 1ns/100ps
`default_nettype none
module uv_trip_asserts #(
	parameter int CYCLES_PER_MS = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Bus and protection ports
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic externalBlockInput,
	input wire logic phaseAStart,
	input wire logic phaseBStart,
	input wire logic phaseCStart,
	input wire logic generalStartOut,
	input wire logic generalTripOut
);
	int startRun;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Length of the present general start
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			startRun <= 0;
		end else if (!generalStartOut) begin
			startRun <= 0;
		end else begin
			startRun <= startRun + 1;
		end
	end
	// Blocking drops the general start on the same edge as the phase flags
	a_gen_start: assert property (
		generalStartOut |-> $past(phaseAStart | phaseBStart | phaseCStart))
		else $error("general start without phase start");
	a_gen_follow: assert property (
		$past(phaseAStart | phaseBStart | phaseCStart)
		&& (phaseAStart | phaseBStart | phaseCStart) |-> generalStartOut)
		else $error("general start missing");
	a_block_start: assert property (
		externalBlockInput |=> !(phaseAStart | phaseBStart | phaseCStart))
		else $error("start while blocked");
	a_block_trip: assert property (
		externalBlockInput [*2] |=> !generalTripOut)
		else $error("trip while blocked");
	a_trip_start: assert property (
		generalTripOut |-> generalStartOut)
		else $error("trip without start");
	a_trip_time: assert property (
		$rose(generalTripOut) |-> startRun >= 50 * CYCLES_PER_MS - 2)
		else $error("trip too early");
	a_ready_wait: assert property (
		psel && $rose(penable) |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("pready too long");
	a_err_pair: assert property (
		pslverr |-> pready && psel && penable)
		else $error("pslverr without pready");
endmodule : uv_trip_asserts
bind definite_time_undervoltage_trip uv_trip_asserts #(
	.CYCLES_PER_MS(CYCLES_PER_MS)
) uv_trip_asserts_inst (
	.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr),
	.externalBlockInput(externalBlockInput),
	.phaseAStart(phaseAStart), .phaseBStart(phaseBStart),
	.phaseCStart(phaseCStart), .generalStartOut(generalStartOut),
	.generalTripOut(generalTripOut));
`default_nettype wire

/* uv_source.sv */
// Upstream magnitude chain model for the trip bench.
// Assumes levels in 0.01 % steps set on clk by the bench.
`timescale 1ns/100ps
`default_nettype none
module uv_source (
	// Clock and commanded levels
	input  wire logic        clk,
	input  wire logic [15:0] lvl [6],
	// Magnitudes to the trip block
	output var  logic [15:0] phaseAMagnitude,
	output var  logic [15:0] phaseBMagnitude,
	output var  logic [15:0] phaseCMagnitude,
	output var  logic [15:0] pairAbMagnitude,
	output var  logic [15:0] pairBcMagnitude,
	output var  logic [15:0] pairCaMagnitude
);
	// One sample of latency, as a real chain would add
	always_ff @(posedge clk) begin
		phaseAMagnitude <= lvl[0];
		phaseBMagnitude <= lvl[1];
		phaseCMagnitude <= lvl[2];
		pairAbMagnitude <= lvl[3];
		pairBcMagnitude <= lvl[4];
		pairCaMagnitude <= lvl[5];
	end
endmodule : uv_source
`default_nettype wire

/* definite_time_undervoltage_trip_test.sv */
// Self-checking bench for the undervoltage trip block.
// Assumes the package, source model and checker compile first.
`timescale 1ns/100ps
`default_nettype none
module definite_time_undervoltage_trip_test;
	import uv_trip_pkg::*;
	localparam int CPM = 10;
	logic        clk, reset_n, psel, penable, pwrite, xblk, rerr;
	logic        pready, pslverr, stA, stB, stC, gSt, gTr, pairs, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [15:0] lvl [6];
	logic [15:0] mag [6];
	int          failCount, checkCount;
	uv_source uv_source_inst (.clk(clk), .lvl(lvl),
		.phaseAMagnitude(mag[0]), .phaseBMagnitude(mag[1]),
		.phaseCMagnitude(mag[2]), .pairAbMagnitude(mag[3]),
		.pairBcMagnitude(mag[4]), .pairCaMagnitude(mag[5]));
	definite_time_undervoltage_trip #(.CYCLES_PER_MS(CPM))
		definite_time_undervoltage_trip_inst (.clk(clk),
		.reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .phaseAMagnitude(mag[0]),
		.phaseBMagnitude(mag[1]), .phaseCMagnitude(mag[2]),
		.pairAbMagnitude(mag[3]), .pairBcMagnitude(mag[4]),
		.pairCaMagnitude(mag[5]), .externalBlockInput(xblk),
		.phaseAStart(stA), .phaseBStart(stB), .phaseCStart(stC),
		.generalStartOut(gSt), .generalTripOut(gTr),
		.pairLabels(pairs), .irq(irq));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : check
	// One APB transfer; waits for pready, no fixed latency assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following setup never reassigns psel at once
		@(posedge clk);
	endtask : apb
	task pause(input int k);
		repeat (k) @(posedge clk);
	endtask : pause
	task setPair(input logic [15:0] a, b, c);
		lvl[3] <= a;
		lvl[4] <= b;
		lvl[5] <= c;
	endtask : setPair
	task automatic tRegs();
		logic [7:0] ad [4] = '{START_ADDR, BLOCK_ADDR, RATIO_ADDR, DELAY_ADDR};
		logic [15:0] ex [4] = '{START_DEF, BLOCK_DEF, RATIO_DEF, DELAY_DEF};
		apb(1'b0, CTRL_ADDR, 32'h0);
		check(rdata, 32'h8);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ad[i], 32'h0);
			check(rdata, ex[i]);
		end
		apb(1'b1, START_ADDR, 32'hC8);
		apb(1'b0, START_ADDR, 32'h0);
		check(rdata, START_MAX);
		apb(1'b1, START_ADDR, 32'h5A);
		apb(1'b1, DELAY_ADDR, 32'hA);
		apb(1'b0, DELAY_ADDR, 32'h0);
		check(rdata, DELAY_MIN);
		apb(1'b0, 8'h20, 32'h0);
		check({rerr, pairs}, 2'h3);
		$display("register test done");
	endtask : tRegs
	task tTrip();
		int n;
		apb(1'b1, IRQMSK_ADDR, 32'h3);
		apb(1'b1, CTRL_ADDR, 32'h9);
		setPair(16'h1388, 16'h2710, 16'h2710);
		pause(6);
		check({stA, stB, stC, gSt, irq}, 5'h13);
		n = 6;
		while (gTr !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check(n >= 50 * CPM && n <= 50 * CPM + 20, 1'b1);
		// Interrupt masked, unmasked, then cleared
		apb(1'b1, IRQMSK_ADDR, 32'h0);
		pause(3);
		check(irq, 1'b0);
		apb(1'b1, IRQMSK_ADDR, 32'h3);
		pause(3);
		check(irq, 1'b1);
		apb(1'b1, IRQST_ADDR, 32'h3);
		pause(3);
		check(irq, 1'b0);
		// Block drops a standing trip; then the timer holds in the band
		xblk <= 1'b1;
		pause(3);
		check(gTr, 1'b0);
		xblk <= 1'b0;
		pause(300);
		setPair(16'h23F0, 16'h2710, 16'h2710);
		pause(300);
		check({stA, gTr}, 2'h2);
		setPair(16'h1388, 16'h2710, 16'h2710);
		pause(260);
		check(gTr, 1'b1);
		setPair(16'h23F0, 16'h2710, 16'h2710);
		pause(6);
		check({stA, gTr}, 2'h3);
		setPair(16'h251C, 16'h2710, 16'h2710);
		pause(6);
		check({stA, gTr}, 2'h0);
		$display("trip test done");
	endtask : tTrip
	task tBlock();
		setPair(16'h0384, 16'h2710, 16'h2710);
		pause(6);
		check(stA, 1'b0);
		setPair(16'h03E8, 16'h2710, 16'h2710);
		pause(6);
		check(stA, 1'b0);
		setPair(16'h044C, 16'h2710, 16'h2710);
		pause(6);
		check(stA, 1'b1);
		xblk <= 1'b1;
		pause(6);
		check({stA, gSt}, 2'h0);
		xblk <= 1'b0;
		pause(6);
		check(stA, 1'b1);
		$display("block test done");
	endtask : tBlock
	task tModes();
		apb(1'b1, CTRL_ADDR, 32'hA);
		setPair(16'h1388, 16'h2710, 16'h2710);
		pause(600);
		check(gTr, 1'b0);
		setPair(16'h1388, 16'h1388, 16'h2710);
		pause(600);
		check(gTr, 1'b1);
		apb(1'b1, CTRL_ADDR, 32'hB);
		pause(6);
		check(gTr, 1'b0);
		apb(1'b1, CTRL_ADDR, 32'hF);
		setPair(16'h1388, 16'h1388, 16'h1388);
		pause(600);
		check({gSt, gTr}, 2'h2);
		apb(1'b1, CTRL_ADDR, 32'h8);
		pause(6);
		check(gSt, 1'b0);
		apb(1'b1, CTRL_ADDR, 32'h1);
		pause(6);
		check({pairs, stA}, 2'h0);
		lvl[0] <= 16'h1388;
		pause(6);
		check(stA, 1'b1);
		$display("mode test done");
	endtask : tModes
	task finalReport();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finalReport
	// Main sequence
	initial begin
		reset_n = 1'b0;
		{psel, penable, pwrite, xblk} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		foreach (lvl[i]) lvl[i] = 16'h2710;
		failCount = 0;
		checkCount = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		tRegs();
		tTrip();
		tBlock();
		tModes();
		finalReport();
	end
	// Watchdog, well past the roughly 3300 cycles of the run
	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		finalReport();
	end
endmodule : definite_time_undervoltage_trip_test
`default_nettype wire
